// ### clock_ctrl_wp_pkg.sv
package clock_ctrl_wp_pkg;

  // ****************************************************************
  // register byte addresses
  // ****************************************************************
  localparam logic [31:0] BLOCK_BASE       = 32'h400E0400;  // base for violation offsets
  localparam logic [31:0] ADDR_SYSCLK_EN   = 32'h400E0580;  // system clock enable
  localparam logic [31:0] ADDR_SYSCLK_DIS  = 32'h400E0584;  // system clock disable
  localparam logic [31:0] ADDR_PERCLK_EN   = 32'h400E0588;  // peripheral clock enable
  localparam logic [31:0] ADDR_PERCLK_DIS  = 32'h400E058C;  // peripheral clock disable
  localparam logic [31:0] ADDR_MAIN_OSC    = 32'h400E0590;  // main oscillator
  localparam logic [31:0] ADDR_PLL         = 32'h400E0594;  // pll
  localparam logic [31:0] ADDR_MASTER_CLK  = 32'h400E0598;  // master clock
  localparam logic [31:0] ADDR_PROG_CLK    = 32'h400E059C;  // programmable clock
  localparam logic [31:0] ADDR_FAST_MODE   = 32'h400E0470;  // fast start-up mode
  localparam logic [31:0] ADDR_FAST_POL    = 32'h400E0474;  // fast start-up polarity
  localparam logic [31:0] ADDR_FAULT_CLR   = 32'h400E0478;  // fault output clear
  localparam logic [31:0] ADDR_PROT_MODE   = 32'h400E04E4;  // protect_mode
  localparam logic [31:0] ADDR_PROT_STATUS = 32'h400E04E8;  // protect_status
  localparam logic [31:0] ADDR_RC_TRIM     = 32'h400E0510;  // rc_trim_config
  localparam logic [31:0] ADDR_FAULT_STAT  = 32'h400E0600;  // fault output status
  localparam logic [31:0] ADDR_IRQ_STATUS  = 32'h400E0604;  // sticky event bits
  localparam logic [31:0] ADDR_IRQ_MASK    = 32'h400E0608;  // event mask

  // ****************************************************************
  // field layouts and values
  // ****************************************************************
  localparam logic [23:0] KEY_PASSWORD  = 24'h504D43;  // key_password
  localparam int          KEY_LSB       = 8;           // protect_key position
  localparam int          ENABLE_BIT    = 0;           // protect_enable position
  localparam int          VFLAG_BIT     = 0;           // violation_flag position
  localparam int          VSRC_LSB      = 8;           // violation_source position
  localparam int          TRIM_W        = 7;           // width of one trim value
  localparam int          TRIM4_LSB     = 0;           // 4 MHz byte
  localparam int          TRIM8_LSB     = 8;           // 8 MHz byte
  localparam int          TRIM12_LSB    = 16;          // 12 MHz byte
  localparam int          TRIM_SEL_OFS  = 7;           // select bit inside each byte
  localparam logic [23:0] TRIM_USED     = 24'hFFFFFF;  // implemented trim bits
  localparam int          EVT_VIOLATION = 0;           // irq bit: protection violation
  localparam int          EVT_FAULT     = 1;           // irq bit: fault output raised
  localparam int          EVT_W         = 2;           // number of events
  localparam logic [23:0] RC_TRIM_RESET = 24'h000000;  // rc_trim_config after reset
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;        // ahb nonsequential
  localparam logic        HRESP_OKAY    = 1'b0;        // ahb okay response

endpackage

// ### rc_trim_select.sv
`timescale 1ns/1ns
module rc_trim_select (
  input  wire logic                                i_clk,      // system clock
  input  wire logic                                i_reset_n,  // async reset, low
  input  wire logic                                i_select,   // 1 = user value
  input  wire logic [clock_ctrl_wp_pkg::TRIM_W-1:0] i_user,     // user trim value
  input  wire logic [clock_ctrl_wp_pkg::TRIM_W-1:0] i_factory,  // factory trim value
  output logic      [clock_ctrl_wp_pkg::TRIM_W-1:0] o_trim      // applied trim
);
  import clock_ctrl_wp_pkg::*;

  // ****************************************************************
  // registered selection between factory and user trim
  // ****************************************************************
  // flop keeps the oscillator trim glitch free when software rewrites it
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_trim <= '0;
    end else if (i_select) begin
      o_trim <= i_user;     // user calibration
    end else begin
      o_trim <= i_factory;  // value from flash
    end
  end

endmodule

// ### clock_ctrl_write_protect.sv
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ns
module clock_ctrl_write_protect (
  input  wire logic                                i_clk,          // system clock
  input  wire logic                                i_reset_n,      // async reset, low
  input  wire logic                                i_hsel,         // ahb slave select
  input  wire logic [31:0]                         i_haddr,        // ahb address
  input  wire logic [1:0]                          i_htrans,       // ahb transfer type
  input  wire logic                                i_hwrite,       // ahb write
  input  wire logic [2:0]                          i_hsize,        // ahb size, word only
  input  wire logic [31:0]                         i_hwdata,       // ahb write data
  input  wire logic                                i_hready,       // ahb bus ready
  output logic                                     o_hreadyout,    // ahb slave ready
  output logic                                     o_hresp,        // ahb response
  output logic      [31:0]                         o_hrdata,       // ahb read data
  input  wire logic                                i_cfd_fault,    // fault detect pulse
  input  wire logic [clock_ctrl_wp_pkg::TRIM_W-1:0] i_flash_trim4,  // flash 4 MHz trim
  input  wire logic [clock_ctrl_wp_pkg::TRIM_W-1:0] i_flash_trim8,  // flash 8 MHz trim
  input  wire logic [clock_ctrl_wp_pkg::TRIM_W-1:0] i_flash_trim12, // flash 12 MHz trim
  output logic      [clock_ctrl_wp_pkg::TRIM_W-1:0] o_rc_trim4,     // applied 4 MHz trim
  output logic      [clock_ctrl_wp_pkg::TRIM_W-1:0] o_rc_trim8,     // applied 8 MHz trim
  output logic      [clock_ctrl_wp_pkg::TRIM_W-1:0] o_rc_trim12,    // applied 12 MHz trim
  output logic                                     o_fault_out,    // latched fault output
  output logic                                     o_cfg_wr,       // accepted cfg write
  output logic      [31:0]                         o_cfg_addr,     // its address
  output logic      [31:0]                         o_cfg_wdata,    // its data
  output logic                                     o_irq           // interrupt, high
);
  import clock_ctrl_wp_pkg::*;

  // ****************************************************************
  // bus front end
  // ****************************************************************
  logic        pend;             // data phase in progress
  logic [31:0] p_addr;           // latched address
  logic        p_write;          // latched direction
  logic        protect_enable;   // write protection on
  logic        violation_flag;   // sticky violation
  logic [15:0] violation_source; // offending offset
  logic [23:0] rc_trim_config;   // trim selectors and values
  logic [EVT_W-1:0] irq_status;  // sticky events
  logic [EVT_W-1:0] irq_mask;    // event enables
  logic [31:0] read_value;       // read mux output
  logic [31:0] offset_full;      // address minus base
  logic        addr_phase;       // address phase accepted
  logic        do_wr;            // write in data phase
  logic        do_rd;            // read in data phase
  logic        is_prot;          // target is protected
  logic        prot_refuse;      // write refused
  logic        wr_ok;            // write allowed
  logic        rd_status;        // protect_status read
  logic        key_ok;           // key matches password
  logic        fault_clear;      // fault clear write

  assign addr_phase = i_hsel && (i_htrans == HTRANS_NONSEQ) && i_hready && o_hreadyout;
  assign do_wr      = pend && p_write;
  assign do_rd      = pend && !p_write;
  assign key_ok     = (i_hwdata[31:KEY_LSB] == KEY_PASSWORD);
  assign offset_full = p_addr - BLOCK_BASE;
  assign rd_status  = do_rd && (p_addr == ADDR_PROT_STATUS);
  assign fault_clear = do_wr && (p_addr == ADDR_FAULT_CLR) && i_hwdata[0];

  // protected register decode
  always_comb begin
    unique case (p_addr)
      ADDR_SYSCLK_EN, ADDR_SYSCLK_DIS, ADDR_PERCLK_EN, ADDR_PERCLK_DIS,
      ADDR_MAIN_OSC, ADDR_PLL, ADDR_MASTER_CLK, ADDR_PROG_CLK,
      ADDR_FAST_MODE, ADDR_FAST_POL, ADDR_RC_TRIM: begin
        is_prot = 1'b1;  // clock configuration register
      end
      default: begin
        is_prot = 1'b0;  // anything else
      end
    endcase
  end

  assign prot_refuse = do_wr && is_prot && protect_enable;
  assign wr_ok       = do_wr && !(is_prot && protect_enable);

  // capture the address phase
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pend    <= 1'b0;
      p_addr  <= '0;
      p_write <= 1'b0;
    end else begin
      pend <= addr_phase;
      if (addr_phase) begin
        p_addr  <= i_haddr;   // hsize is always a word here
        p_write <= i_hwrite;
      end
    end
  end

  // one wait state: ready drops for the data phase cycle
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_hreadyout <= 1'b1;
    end else if (addr_phase) begin
      o_hreadyout <= 1'b0;
    end else if (pend) begin
      o_hreadyout <= 1'b1;
    end
  end

  // response is always okay
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_hresp <= HRESP_OKAY;
    end else begin
      o_hresp <= HRESP_OKAY;
    end
  end

  // read mux, unmapped reads give zero
  always_comb begin
    read_value = '0;
    unique case (p_addr)
      ADDR_PROT_MODE: begin
        read_value[ENABLE_BIT] = protect_enable;  // key bits stay zero
      end
      ADDR_PROT_STATUS: begin
        read_value[VFLAG_BIT] = violation_flag;
        read_value[VSRC_LSB +: 16] = violation_source;
      end
      ADDR_RC_TRIM: begin
        read_value[23:0] = rc_trim_config;
      end
      ADDR_FAULT_STAT: begin
        read_value[0] = o_fault_out;
      end
      ADDR_IRQ_STATUS: begin
        read_value[EVT_W-1:0] = irq_status;
      end
      ADDR_IRQ_MASK: begin
        read_value[EVT_W-1:0] = irq_mask;
      end
      default: begin
        read_value = '0;                          // unmapped
      end
    endcase
  end

  // read data register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_hrdata <= '0;
    end else if (do_rd) begin
      o_hrdata <= read_value;
    end
  end

  // ****************************************************************
  // write protection
  // ****************************************************************
  // enable only changes with the correct key
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      protect_enable <= 1'b0;
    end else if (do_wr && (p_addr == ADDR_PROT_MODE) && key_ok) begin
      protect_enable <= i_hwdata[ENABLE_BIT];
    end
  end

  // violation flag and source, a new violation beats the read clear
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      violation_flag   <= 1'b0;
      violation_source <= '0;
    end else if (prot_refuse) begin
      violation_flag   <= 1'b1;
      violation_source <= offset_full[15:0];
    end else if (rd_status) begin
      violation_flag   <= 1'b0;
      violation_source <= '0;
    end
  end

  // forward accepted writes to the other clock configuration registers
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_cfg_wr    <= 1'b0;
      o_cfg_addr  <= '0;
      o_cfg_wdata <= '0;
    end else begin
      o_cfg_wr <= wr_ok && is_prot && (p_addr != ADDR_RC_TRIM);
      if (wr_ok && is_prot) begin
        o_cfg_addr  <= p_addr;
        o_cfg_wdata <= i_hwdata;
      end
    end
  end

  // ****************************************************************
  // rc oscillator trim
  // ****************************************************************
  // trim register, locked while protected
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rc_trim_config <= RC_TRIM_RESET;
    end else if (wr_ok && (p_addr == ADDR_RC_TRIM)) begin
      rc_trim_config <= i_hwdata[23:0] & TRIM_USED;
    end
  end

  // 4 MHz selector
  rc_trim_select u_trim4 (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_select  (rc_trim_config[TRIM4_LSB + TRIM_SEL_OFS]),
    .i_user    (rc_trim_config[TRIM4_LSB +: TRIM_W]),
    .i_factory (i_flash_trim4),
    .o_trim    (o_rc_trim4)
  );

  // 8 MHz selector
  rc_trim_select u_trim8 (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_select  (rc_trim_config[TRIM8_LSB + TRIM_SEL_OFS]),
    .i_user    (rc_trim_config[TRIM8_LSB +: TRIM_W]),
    .i_factory (i_flash_trim8),
    .o_trim    (o_rc_trim8)
  );

  // 12 MHz selector
  rc_trim_select u_trim12 (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_select  (rc_trim_config[TRIM12_LSB + TRIM_SEL_OFS]),
    .i_user    (rc_trim_config[TRIM12_LSB +: TRIM_W]),
    .i_factory (i_flash_trim12),
    .o_trim    (o_rc_trim12)
  );

  // ****************************************************************
  // fault output and interrupts
  // ****************************************************************
  // latched fault output, a new fault beats the clear
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_fault_out <= 1'b0;
    end else if (i_cfd_fault) begin
      o_fault_out <= 1'b1;
    end else if (fault_clear) begin
      o_fault_out <= 1'b0;
    end
  end

  // sticky event bits, write one to clear, set wins
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_status <= '0;
    end else begin
      for (int i = 0; i < EVT_W; i++) begin
        if ((i == EVT_VIOLATION && prot_refuse) || (i == EVT_FAULT && i_cfd_fault)) begin
          irq_status[i] <= 1'b1;
        end else if (do_wr && (p_addr == ADDR_IRQ_STATUS) && i_hwdata[i]) begin
          irq_status[i] <= 1'b0;
        end
      end
    end
  end

  // mask register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_mask <= '0;
    end else if (do_wr && (p_addr == ADDR_IRQ_MASK)) begin
      irq_mask <= i_hwdata[EVT_W-1:0];
    end
  end

  // level interrupt, one cycle behind the status bits
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_status & irq_mask);
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_key_match_sets: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    do_wr && (p_addr == ADDR_PROT_MODE) && key_ok |=> protect_enable == $past(i_hwdata[0]))
    else $error("protection enable not taken with good key");
  a_key_bad_holds: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    do_wr && (p_addr == ADDR_PROT_MODE) && !key_ok |=> $stable(protect_enable))
    else $error("protection enable changed with bad key");
  a_key_reads_zero: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    do_rd && (p_addr == ADDR_PROT_MODE) |=> o_hrdata[31:1] == 31'h0 && o_hreadyout)
    else $error("key field read not zero");
  a_refuse_no_forward: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    prot_refuse |=> !o_cfg_wr)
    else $error("protected write forwarded");
  a_flag_sticky: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    violation_flag && !rd_status |=> violation_flag)
    else $error("violation flag lost before read");
  a_source_capture: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    prot_refuse |=> violation_flag && violation_source == $past(offset_full[15:0]))
    else $error("violation source not captured");
  a_read_clears: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    rd_status && !prot_refuse |=> !violation_flag && violation_source == 16'h0)
    else $error("status read did not clear");
  a_trim_locked: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    do_wr && (p_addr == ADDR_RC_TRIM) && protect_enable |=> $stable(rc_trim_config))
    else $error("trim written while protected");
  a_trim4_mux: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    rc_trim_config[TRIM4_LSB + TRIM_SEL_OFS] |=> o_rc_trim4 == $past(rc_trim_config[6:0]))
    else $error("4 MHz user trim not applied");
  a_trim8_mux: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !rc_trim_config[TRIM8_LSB + TRIM_SEL_OFS] |=> o_rc_trim8 == $past(i_flash_trim8))
    else $error("8 MHz flash trim not applied");
  a_trim12_mux: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    rc_trim_config[TRIM12_LSB + TRIM_SEL_OFS] |=> o_rc_trim12 == $past(rc_trim_config[22:16]))
    else $error("12 MHz user trim not applied");
  a_fault_cleared: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    fault_clear && !i_cfd_fault |=> !o_fault_out)
    else $error("fault output not cleared");
  a_fault_status: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    do_rd && (p_addr == ADDR_FAULT_STAT) |=> o_hrdata[0] == $past(o_fault_out))
    else $error("fault status read wrong");
  a_irq_follows: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    prot_refuse && irq_mask[EVT_VIOLATION] |-> ##2 o_irq)
    else $error("violation interrupt missing");

endmodule

// ### test_clock_ctrl_write_protect.sv
`timescale 1ns/1ns
module test_clock_ctrl_write_protect;
  import clock_ctrl_wp_pkg::*;
  // ************************************************************
  // bench signals
  // ************************************************************
  logic        i_clk, i_reset_n, i_hsel, i_hwrite, i_cfd_fault;  // clock, reset, bus controls
  logic [31:0] i_haddr, i_hwdata;                                 // bus address and data
  logic [1:0]  i_htrans;                                          // transfer type
  logic [2:0]  i_hsize;                                           // always a word
  logic [6:0]  i_flash_trim4, i_flash_trim8, i_flash_trim12;      // factory trims
  logic        o_hreadyout, o_hresp, o_fault_out, o_cfg_wr, o_irq; // design outputs
  logic [31:0] o_hrdata, o_cfg_addr, o_cfg_wdata;                 // design data outputs
  logic [6:0]  o_rc_trim4, o_rc_trim8, o_rc_trim12;               // applied trims
  int          bad_count, checked, cycles, cfg_count;             // counters
  logic [31:0] rd;                                                // last read data
  localparam logic [31:0] PROT [10] = '{ADDR_SYSCLK_EN, ADDR_SYSCLK_DIS, ADDR_PERCLK_EN,
    ADDR_PERCLK_DIS, ADDR_MAIN_OSC, ADDR_PLL, ADDR_MASTER_CLK, ADDR_PROG_CLK,
    ADDR_FAST_MODE, ADDR_FAST_POL};                               // protected clock regs
  clock_ctrl_write_protect DUT (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_hsel(i_hsel),
    .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize),
    .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp), .o_hrdata(o_hrdata), .i_cfd_fault(i_cfd_fault),
    .i_flash_trim4(i_flash_trim4), .i_flash_trim8(i_flash_trim8),
    .i_flash_trim12(i_flash_trim12), .o_rc_trim4(o_rc_trim4), .o_rc_trim8(o_rc_trim8),
    .o_rc_trim12(o_rc_trim12), .o_fault_out(o_fault_out), .o_cfg_wr(o_cfg_wr),
    .o_cfg_addr(o_cfg_addr), .o_cfg_wdata(o_cfg_wdata), .o_irq(o_irq));
  // ************************************************************
  // clock, forwarded write counter and hang guard
  // ************************************************************
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  // count each accepted configuration write pulse, sampled mid cycle where it is settled
  always @(negedge i_clk) begin
    if (o_cfg_wr === 1'b1) cfg_count <= cfg_count + 1;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count = bad_count + 1;
      summarize();
    end
  end
  // ************************************************************
  // tasks
  // ************************************************************
  // compare one value, report and count a mismatch
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // wait for an edge with hready high; data is stable in the low half before it
  task automatic wait_ready(output logic [31:0] d);
    logic r;
    r = 1'b0;
    d = '0;
    while (r !== 1'b1) begin
      @(negedge i_clk);
      r = o_hreadyout;
      d = o_hrdata;
      @(posedge i_clk);
    end
  endtask
  // one single word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    @(posedge i_clk);  // start every request just after a rising edge
    i_hsel   <= 1'b1;
    i_haddr  <= a;
    i_hwrite <= w;
    i_htrans <= HTRANS_NONSEQ;
    wait_ready(x);
    i_htrans <= 2'h0;
    i_hwdata <= d;
    wait_ready(rd);
    i_hsel   <= 1'b0;
    check("hresp", {31'h0, o_hresp}, {31'h0, HRESP_OKAY});
  endtask
  // read and compare a register
  task automatic rchk(input string name, input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(name, rd, exp);
  endtask
  // expected trim for one byte of the trim register
  function automatic logic [6:0] pick(input logic [7:0] b, input logic [6:0] f);
    return b[7] ? b[6:0] : f;
  endfunction
  // write trims and check all three applied values
  task automatic trim(input logic [31:0] v);
    bus(1'b1, ADDR_RC_TRIM, v);
    repeat (2) @(negedge i_clk);
    check("trim4", o_rc_trim4, pick(v[7:0], i_flash_trim4));
    check("trim8", o_rc_trim8, pick(v[15:8], i_flash_trim8));
    check("trim12", o_rc_trim12, pick(v[23:16], i_flash_trim12));
    rchk("trim_rd", ADDR_RC_TRIM, v & 32'h00FFFFFF);
  endtask
  // final counts and verdict
  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    {i_hsel, i_hwrite, i_cfd_fault, i_reset_n} = 4'h0;
    {i_haddr, i_hwdata, i_htrans} = '0;
    i_hsize = 3'h2;
    i_flash_trim4 = 7'h11;
    i_flash_trim8 = 7'h22;
    i_flash_trim12 = 7'h33;
    {bad_count, checked, cycles, cfg_count} = '0;
    repeat (4) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rchk("mode_rst", ADDR_PROT_MODE, 32'h0);
    rchk("stat_rst", ADDR_PROT_STATUS, 32'h0);
    rchk("unmapped", 32'h400E0700, 32'h0);
    $display("test reset done");
    trim(32'h0);
    trim(32'h00C5A481);
    trim(32'h0045A401);
    $display("test trim done");
    bus(1'b1, ADDR_PROT_MODE, 32'h12345601);
    rchk("mode_badkey", ADDR_PROT_MODE, 32'h0);
    bus(1'b1, ADDR_SYSCLK_EN, 32'h0000A5A5);
    check("cfg_open", cfg_count, 1);
    check("cfg_addr", o_cfg_addr, ADDR_SYSCLK_EN);
    $display("test wrong key done");
    bus(1'b1, ADDR_PROT_MODE, {KEY_PASSWORD, 8'h01});
    rchk("mode_on", ADDR_PROT_MODE, 32'h1);
    foreach (PROT[i]) begin
      bus(1'b1, PROT[i], 32'h5A5A0000 + i);
      check("cfg_block", cfg_count, 1);
      rchk("mode_mid", ADDR_PROT_MODE, 32'h1);
      rchk("stat_viol", ADDR_PROT_STATUS, (((PROT[i] - BLOCK_BASE) & 32'hFFFF) << 8) | 1);
      rchk("stat_clr", ADDR_PROT_STATUS, 32'h0);
    end
    bus(1'b1, ADDR_RC_TRIM, 32'h00FFFFFF);
    rchk("trim_keep", ADDR_RC_TRIM, 32'h0045A401);
    rchk("stat_trim", ADDR_PROT_STATUS, 32'h00011001);
    $display("test protection done");
    check("irq_masked", o_irq, 1'b0);
    bus(1'b1, ADDR_IRQ_MASK, 32'h3);
    repeat (2) @(negedge i_clk);
    check("irq_on", o_irq, 1'b1);
    rchk("irq_stat", ADDR_IRQ_STATUS, 32'h1);
    bus(1'b1, ADDR_IRQ_STATUS, 32'h1);
    repeat (2) @(negedge i_clk);
    check("irq_off", o_irq, 1'b0);
    bus(1'b1, ADDR_MAIN_OSC, 32'h00000001);
    repeat (2) @(negedge i_clk);
    check("irq_viol", o_irq, 1'b1);
    rchk("stat_osc", ADDR_PROT_STATUS, 32'h00019001);
    bus(1'b1, ADDR_IRQ_STATUS, 32'h1);
    $display("test interrupt done");
    bus(1'b1, ADDR_PROT_MODE, {KEY_PASSWORD, 8'h00});
    rchk("mode_off", ADDR_PROT_MODE, 32'h0);
    bus(1'b1, ADDR_FAST_POL, 32'h0000BEEF);
    check("cfg_reopen", cfg_count, 2);
    check("cfg_data", o_cfg_wdata, 32'h0000BEEF);
    $display("test unlock done");
    @(posedge i_clk);
    i_cfd_fault <= 1'b1;
    @(posedge i_clk);
    i_cfd_fault <= 1'b0;
    rchk("fault_stat", ADDR_FAULT_STAT, 32'h1);
    check("fault_irq", o_irq, 1'b1);
    bus(1'b1, ADDR_FAULT_CLR, 32'h1);
    @(negedge i_clk);
    check("fault_out", o_fault_out, 1'b0);
    rchk("fault_clr", ADDR_FAULT_STAT, 32'h0);
    $display("test fault done");
    summarize();
  end
endmodule
